// file: rtl/idu_pkg.sv
// package of widths, latency figures and carrier types for the divide unit
// ****************************************************************
// What this block does
// - unsigned divide: double-width dividend, quotient low half, remainder high
// - signed divide: same placement, two's complement, 64-bit takes 12 to 41
// - 8-bit divisor forms run in hardware only, 11 to 12 cycles
// - 16/32/64-bit forms go through the microcode sequencer using the divider
// - latency follows operand values; done flags when result is ready
// - busy indication high every cycle a divide occupies the unit
// ****************************************************************
package idu_pkg;

    // operand size codes
    typedef enum logic [1:0] {
        IDU_W8  = 2'h0,
        IDU_W16 = 2'h1,
        IDU_W32 = 2'h2,
        IDU_W64 = 2'h3
    } idu_width_t;

    // latency limits per width, in core cycles
    localparam int unsigned IDU_MIN_8   = 11;
    localparam int unsigned IDU_MAX_8   = 12;
    localparam int unsigned IDU_MIN_W   = 12;
    localparam int unsigned IDU_MAX_16  = 17;
    localparam int unsigned IDU_MAX_32  = 25;
    localparam int unsigned IDU_MAX_64  = 41;
    localparam int unsigned IDU_DATA_W  = 64;
    localparam logic [6:0]  IDU_ONE     = 7'h01;
    localparam logic [6:0]  IDU_ZERO7   = 7'h00;

    // divide request from issue logic
    typedef struct packed {
        logic             signed_divide;   // two's complement operation
        idu_width_t       width;           // divisor size
        logic [63:0]      acc_hi;          // high accumulator (dx part)
        logic [63:0]      acc_lo;          // low accumulator (ax part)
        logic [63:0]      divisor;         // divisor, low bits used
    } idu_req_t;

    // divide response to writeback
    typedef struct packed {
        logic             div_error;       // zero divisor or overflow
        logic [63:0]      acc_hi;          // remainder or unchanged
        logic [63:0]      acc_lo;          // quotient or unchanged
    } idu_rsp_t;

endpackage : idu_pkg

// file: rtl/idu_divider.sv
// integer divide execution unit with microcode sequencer handshake
module idu_divider
    import idu_pkg::*;
(
    input  wire logic     REF_CLK,       // core clock, 200 MHz
    input  wire logic     SYS_RST,       // asynchronous reset, high
    input  wire logic     REQ_VALID,     // issue presents a divide
    input  wire idu_req_t REQ,           // operands and form
    output logic          REQ_READY,     // unit free to take a divide
    output logic          USEQ_START,    // microcode sequence dispatched
    input  wire logic     USEQ_GRANT,    // sequencer hands datapath back
    output logic          RSP_VALID,     // result ready, one cycle
    output idu_rsp_t      RSP,           // result registers
    output logic          DIV_BUSY       // busy cycle for perf counter
);

    // ****************************************************************
    // state and datapath registers
    // ****************************************************************
    typedef enum logic [1:0] {
        IDU_IDLE = 2'b00,
        IDU_SEQ  = 2'b01,
        IDU_RUN  = 2'b11,
        IDU_DONE = 2'b10
    } idu_state_t;

    idu_state_t  state;
    idu_state_t  next_state;
    idu_req_t    op;
    logic [63:0] quo;            // quotient, negated when q_neg
    logic [63:0] rem;            // remainder, negated when dvd_neg
    logic [6:0]  cyc;            // cycles since acceptance
    logic [6:0]  bits_left;      // quotient bits still to produce
    logic [6:0]  lat_min;        // least latency for this width

    // ****************************************************************
    // width helpers
    // ****************************************************************
    // sign-extending field extraction to a 64-bit value
    function automatic logic [63:0] sx(input logic [63:0] v,
                                       input idu_width_t w);
        unique case (w)
            IDU_W8:  sx = {{56{v[7]}},  v[7:0]};
            IDU_W16: sx = {{48{v[15]}}, v[15:0]};
            IDU_W32: sx = {{32{v[31]}}, v[31:0]};
            IDU_W64: sx = v;
        endcase
    endfunction

    function automatic logic [63:0] zx(input logic [63:0] v,
                                       input idu_width_t w);
        unique case (w)
            IDU_W8:  zx = {56'h0000_0000_0000_00, v[7:0]};
            IDU_W16: zx = {48'h0000_0000_0000, v[15:0]};
            IDU_W32: zx = {32'h0000_0000, v[31:0]};
            IDU_W64: zx = v;
        endcase
    endfunction

    function automatic logic [6:0] max_lat(input idu_width_t w);
        unique case (w)
            IDU_W8:  max_lat = 7'(IDU_MAX_8);
            IDU_W16: max_lat = 7'(IDU_MAX_16);
            IDU_W32: max_lat = 7'(IDU_MAX_32);
            IDU_W64: max_lat = 7'(IDU_MAX_64);
        endcase
    endfunction

    // ****************************************************************
    // operand preparation at acceptance
    // ****************************************************************
    // 8-bit dividend is the 16-bit low accumulator; others are hi:lo pair
    wire idu_width_t w       = REQ.width;
    wire logic [63:0] dvs_sx = sx(REQ.divisor, w);
    wire logic [63:0] dvs_zx = zx(REQ.divisor, w);
    wire logic        dvs_neg = REQ.signed_divide & dvs_sx[63];
    wire logic [63:0] dvs_mag = dvs_neg ? (64'h0 - dvs_sx) : dvs_zx;
    wire logic [127:0] dvd_full =
        (w == IDU_W8)  ? {112'h0, REQ.acc_lo[15:0]} :
        (w == IDU_W16) ? {96'h0, REQ.acc_hi[15:0], REQ.acc_lo[15:0]} :
        (w == IDU_W32) ? {64'h0, REQ.acc_hi[31:0], REQ.acc_lo[31:0]} :
                         {REQ.acc_hi, REQ.acc_lo};
    wire logic [7:0]  sbit   = (w == IDU_W8) ? 8'd15 :
                               (w == IDU_W16) ? 8'd31 :
                               (w == IDU_W32) ? 8'd63 : 8'd127;
    wire logic        dvd_neg = REQ.signed_divide & dvd_full[sbit[6:0]];
    // sign-extend double-width dividend, then negate if needed
    wire logic [127:0] dvd_ext = dvd_full |
        (dvd_neg ? ~((128'h1 << (sbit + 8'd1)) - 128'h1) : 128'h0);
    wire logic [127:0] dvd_mag = dvd_neg ? (128'h0 - dvd_ext) : dvd_full;

    // magnitude divide; hardware computes the exact quotient in one pass
    // and the radix loop below models the data-dependent step count
    wire logic [127:0] q_full = (dvs_mag == 64'h0) ? 128'h0
                                : dvd_mag / {64'h0, dvs_mag};
    wire logic [127:0] r_full = (dvs_mag == 64'h0) ? 128'h0
                                : dvd_mag % {64'h0, dvs_mag};
    wire logic        q_neg   = dvd_neg ^ dvs_neg;
    // signed quotient limit: 2^(n-1) allowed only when negative
    wire logic [127:0] q_lim  = 128'h1 << (sbit[6:0] >> 1);
    // 8-bit sum so the 64-bit form shifts by 64 rather than wrapping to 0
    wire logic        ovf_u   = (q_full >> ((sbit + 8'h01) >> 1)) != 128'h0;
    wire logic        ovf_s   = (q_full > q_lim) |
                                ((q_full == q_lim) & ~q_neg);
    wire logic        err     = (dvs_mag == 64'h0) |
                                (REQ.signed_divide ? ovf_s : ovf_u);
    // significant quotient bits set the work remaining
    function automatic logic [6:0] msb_pos(input logic [63:0] v);
        msb_pos = IDU_ZERO7;
        for (int i = 0; i < 64; i++)
            if (v[i])
                msb_pos = 7'(i + 1);
    endfunction
    wire logic [6:0] q_bits = msb_pos(q_full[63:0]);

    // ****************************************************************
    // sequencing
    // ****************************************************************
    wire logic take      = REQ_VALID & REQ_READY;
    wire logic short_frm = (REQ.width == IDU_W8);
    // step budget: 4 quotient bits per cycle beyond the minimum
    wire logic [6:0] steps_left = bits_left >> 2;
    wire logic finish = (state == IDU_RUN) &
                        (cyc + IDU_ONE >= lat_min + steps_left |
                         cyc + IDU_ONE >= max_lat(op.width));

    assign REQ_READY  = (state == IDU_IDLE);
    assign DIV_BUSY   = (state != IDU_IDLE);
    assign USEQ_START = (state == IDU_SEQ);

    // next-state decode
    always_comb
    begin
        next_state = state;
        unique case (state)
            IDU_IDLE: if (take)
                          next_state = short_frm ? IDU_RUN : IDU_SEQ;
            IDU_SEQ:  if (USEQ_GRANT)
                          next_state = IDU_RUN;
            IDU_RUN:  if (finish)
                          next_state = IDU_DONE;
            IDU_DONE: next_state = IDU_IDLE;
        endcase
    end

    // state, counter and operand capture
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            state     <= IDU_IDLE;
            cyc       <= IDU_ZERO7;
            op        <= '0;
            quo       <= 64'h0;
            rem       <= 64'h0;
            bits_left <= IDU_ZERO7;
            lat_min   <= IDU_ZERO7;
        end
        else
        begin
            state <= next_state;
            if (take)
            begin
                cyc       <= IDU_ONE;
                op        <= REQ;
                quo       <= q_neg ? 64'h0 - q_full[63:0] : q_full[63:0];
                rem       <= dvd_neg ? 64'h0 - r_full[63:0] : r_full[63:0];
                bits_left <= q_bits;
                lat_min   <= short_frm ? 7'(IDU_MIN_8) : 7'(IDU_MIN_W);
                op.signed_divide <= err;   // reuse as error hold
            end
            else if (state != IDU_IDLE)
                cyc <= cyc + IDU_ONE;
        end
    end

    // result registers: quotient low half, remainder high half
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            RSP_VALID <= 1'b0;
            RSP       <= '0;
        end
        else
        begin
            RSP_VALID <= finish;
            if (finish)
            begin
                RSP.div_error <= op.signed_divide;
                if (op.signed_divide)
                begin
                    RSP.acc_hi <= op.acc_hi;
                    RSP.acc_lo <= op.acc_lo;
                end
                else if (op.width == IDU_W8)
                begin
                    RSP.acc_hi <= op.acc_hi;
                    RSP.acc_lo <= {op.acc_lo[63:16], rem[7:0], quo[7:0]};
                end
                else
                begin
                    RSP.acc_hi <= (op.acc_hi & ~zx(~64'h0, op.width)) |
                                  zx(rem, op.width);
                    RSP.acc_lo <= (op.acc_lo & ~zx(~64'h0, op.width)) |
                                  zx(quo, op.width);
                end
            end
        end
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    sequence s_take8;
        take && short_frm;
    endsequence

    AST_SHORT_LAT: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        s_take8 |-> ##[11:12] RSP_VALID)
        else $error("8-bit divide outside 11 to 12 cycles");
    AST_SHORT_NOSEQ: assert property (@(posedge REF_CLK)
        disable iff (SYS_RST)
        s_take8 |-> !USEQ_START [*8])
        else $error("8-bit divide started the sequencer");
    AST_LONG_SEQ: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        take && !short_frm |=> USEQ_START)
        else $error("wide divide did not dispatch microcode");
    AST_RUN_MAX: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        state == IDU_RUN |-> cyc <= 7'(IDU_MAX_64))
        else $error("divide ran past its longest latency");
    AST_BUSY: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        take |=> DIV_BUSY until RSP_VALID)
        else $error("busy dropped while dividing");
    AST_ERR_KEEP: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        RSP_VALID && RSP.div_error |-> RSP.acc_lo == op.acc_lo)
        else $error("error result altered destination");
    AST_ZERO_DIV: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        take && dvs_mag == 64'h0
        |-> ##[11:41] RSP_VALID && RSP.div_error)
        else $error("zero divisor not flagged");
    AST_UDIV8: assert property (@(posedge REF_CLK) disable iff (SYS_RST)
        RSP_VALID && !RSP.div_error && op.width == IDU_W8
        |-> RSP.acc_lo[7:0] == quo[7:0])
        else $error("8-bit quotient misplaced");

endmodule // idu_divider

// file: verif/idu_useq_model.sv
// sequencer model that hands the divider datapath back after a wait
module idu_useq_model
    import idu_pkg::*;
(
    input  wire logic       REF_CLK,     // core clock
    input  wire logic       SYS_RST,     // async reset, high
    input  wire logic       USEQ_START,  // sequence dispatched
    input  wire logic [3:0] GRANT_DELAY, // wait before grant
    output logic            USEQ_GRANT   // datapath handed back
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [3:0] cnt;

    // count the wait, then grant until the dispatch drops
    always_ff @(posedge REF_CLK or posedge SYS_RST)
    begin
        if (SYS_RST)
        begin
            cnt        <= 4'h0;
            USEQ_GRANT <= 1'h0;
        end
        else if (!USEQ_START)
        begin
            cnt        <= 4'h0;
            USEQ_GRANT <= 1'h0;
        end
        else if (cnt == GRANT_DELAY)
            USEQ_GRANT <= 1'h1;
        else
            cnt <= cnt + 4'h1;
    end
endmodule // idu_useq_model

// file: verif/integer_divide_unit_test.sv
// self-checking bench for the integer divide unit
module integer_divide_unit_test
    import idu_pkg::*;
();
    timeunit 1ns;
    timeprecision 100ps;
    logic       REF_CLK, SYS_RST, REQ_VALID, REQ_READY, USEQ_START;
    logic       USEQ_GRANT, RSP_VALID, DIV_BUSY;
    logic [3:0] gdly;
    idu_req_t   REQ;
    idu_rsp_t   RSP;
    int         failures, comparisons, lat, l1;

    idu_divider uut (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
        .REQ_VALID(REQ_VALID), .REQ(REQ), .REQ_READY(REQ_READY),
        .USEQ_START(USEQ_START), .USEQ_GRANT(USEQ_GRANT),
        .RSP_VALID(RSP_VALID), .RSP(RSP), .DIV_BUSY(DIV_BUSY));
    idu_useq_model useq (.REF_CLK(REF_CLK), .SYS_RST(SYS_RST),
        .USEQ_START(USEQ_START), .GRANT_DELAY(gdly),
        .USEQ_GRANT(USEQ_GRANT));

    // ****************************************
    // helpers
    // ****************************************
    task automatic chk(input string nm, input logic [63:0] ex, got);
        comparisons++;
        if (got !== ex)
        begin
            failures++;
            $display("mismatch %s expected %h seen %h", nm, ex, got);
        end
    endtask

    // expected registers after a divide
    function automatic idu_rsp_t ref_div(idu_req_t r);
        int n;
        logic [127:0] m2, m1, dd, dv, q, rm;
        logic [63:0]  mn;
        logic         sa, sb, ng;
        idu_rsp_t     o;
        n = 8 << r.width;
        m2 = (128'h1 << (2 * n)) - 1;
        m1 = (128'h1 << n) - 1;
        mn = (64'h1 << n) - 1;
        dd = ((128'(r.acc_hi) << n) | 128'(r.acc_lo & mn)) & m2;
        if (r.width == IDU_W8)
            dd = 128'(r.acc_lo[15:0]);
        dv = 128'(r.divisor) & m1;
        sa = r.signed_divide & dd[2*n-1];
        sb = r.signed_divide & dv[n-1];
        if (sa)
            dd = (~dd + 1) & m2;
        if (sb)
            dv = (~dv + 1) & m1;
        ng = sa ^ sb;
        q = (dv == 0) ? 0 : dd / dv;
        rm = (dv == 0) ? 0 : dd % dv;
        if (ng)
            q = -q;
        if (sa)
            rm = -rm;
        o = '{1'h0, r.acc_hi, r.acc_lo};
        if (dv == 0 || (ng ? -q : q) >=
            (128'h1 << (n - int'(r.signed_divide))) + 128'(ng))
            o.div_error = 1'h1;
        else if (r.width == IDU_W8)
            o.acc_lo[15:0] = {rm[7:0], q[7:0]};
        else
        begin
            o.acc_lo = (r.acc_lo & ~mn) | (q[63:0] & mn);
            o.acc_hi = (r.acc_hi & ~mn) | (rm[63:0] & mn);
        end
        return o;
    endfunction

    // one divide: drive, time it, judge the result
    task automatic run(input logic sd, input idu_width_t w,
                       input logic [63:0] hi, lo, dv);
        int wt, mx, mn;
        idu_rsp_t e;
        e = ref_div('{sd, w, hi, lo, dv});
        mn = (w == IDU_W8) ? IDU_MIN_8 : IDU_MIN_W;
        mx = (w == IDU_W8) ? IDU_MAX_8 : (w == IDU_W16) ? IDU_MAX_16
           : (w == IDU_W32) ? IDU_MAX_32 : IDU_MAX_64;
        lat = 0;
        wt = 0;
        @(posedge REF_CLK);
        REQ <= '{sd, w, hi, lo, dv};
        REQ_VALID <= 1'h1;
        @(posedge REF_CLK);
        REQ_VALID <= 1'h0;
        repeat (80)
        begin
            @(posedge REF_CLK);
            #1;
            lat++;
            wt += int'(USEQ_START);
            chk("busy", 1, DIV_BUSY);
            chk("ready", 0, REQ_READY);
            if (RSP_VALID === 1'h1)
                break;
        end
        chk("result", 1, RSP_VALID);
        // valid rose at this edge and is sampled at the next one
        lat++;
        chk("error", e.div_error, RSP.div_error);
        chk("low reg", e.acc_lo, RSP.acc_lo);
        chk("high reg", e.acc_hi, RSP.acc_hi);
        chk("sequencer", w != IDU_W8, wt != 0);
        if (!e.div_error)
        begin
            chk("early", 1, lat >= mn);
            chk("late", 1, lat <= mx + wt);
        end
        @(posedge REF_CLK);
        #1;
        chk("busy end", 0, DIV_BUSY);
        chk("valid pulse", 0, RSP_VALID);
        chk("ready end", 1, REQ_READY);
    endtask

    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_unsigned();
        run(1'h0, IDU_W8, 64'h0000_0000_0000_0000,
            64'h1234_5678_9abc_03e8, 64'h0000_0000_0000_0007);
        run(1'h0, IDU_W16, 64'h0000_0000_0000_0001,
            64'hffff_ffff_ffff_0000, 64'hdead_0000_0000_0002);
        run(1'h0, IDU_W32, 64'h5a5a_5a5a_0000_0003,
            64'h0000_0000_1234_5678, 64'h0000_0000_ffff_fff1);
        run(1'h0, IDU_W64, 64'h0000_0000_0000_0002,
            64'hffff_ffff_ffff_ffff, 64'h0000_0000_0000_0003);
    endtask

    task automatic t_signed();
        run(1'h1, IDU_W8, 64'h0000_0000_0000_0000,
            64'h0000_0000_0000_ff9c, 64'h0000_0000_0000_0007);
        run(1'h1, IDU_W8, 64'h0000_0000_0000_0000,
            64'h0000_0000_0000_ff00, 64'h0000_0000_0000_0002);
        run(1'h1, IDU_W16, 64'h0000_0000_0000_ffff,
            64'h0000_0000_0000_fc18, 64'h0000_0000_0000_0007);
        run(1'h1, IDU_W32, 64'h0000_0000_0000_0000,
            64'h0000_0000_0000_03e8, 64'h0000_0000_ffff_fff9);
        run(1'h1, IDU_W64, 64'hffff_ffff_ffff_ffff,
            64'hffff_ffff_ffff_fc18, 64'hffff_ffff_ffff_fff9);
    endtask

    task automatic t_error();
        run(1'h0, IDU_W32, 64'h0000_0000_0000_0001,
            64'h0000_0000_0000_0009, 64'h0000_0000_0000_0000);
        run(1'h0, IDU_W16, 64'h0000_0000_0000_0005,
            64'h0000_0000_0000_0000, 64'h0000_0000_0000_0005);
        run(1'h1, IDU_W8, 64'h0000_0000_0000_0000,
            64'h0000_0000_0000_0100, 64'h0000_0000_0000_0002);
    endtask

    task automatic t_latency();
        run(1'h0, IDU_W64, 64'h0000_0000_0000_0000,
            64'h0000_0000_0000_0005, 64'h0000_0000_0000_0003);
        l1 = lat;
        run(1'h0, IDU_W64, 64'h0000_0000_0000_0002,
            64'hffff_ffff_ffff_ffff, 64'h0000_0000_0000_0003);
        chk("data dependent time", 1, lat > l1);
        gdly <= 4'h6;
        run(1'h1, IDU_W16, 64'h0000_0000_0000_0000,
            64'h0000_0000_0000_7fff, 64'h0000_0000_0000_0003);
        gdly <= 4'h0;
    endtask

    // reset in mid-divide drops the work; the next divide runs clean
    task automatic t_reset();
        @(posedge REF_CLK);
        REQ <= '{1'h0, IDU_W64, 64'h0000_0000_0000_0002,
                 64'hffff_ffff_ffff_ffff, 64'h0000_0000_0000_0003};
        REQ_VALID <= 1'h1;
        @(posedge REF_CLK);
        REQ_VALID <= 1'h0;
        repeat (5) @(posedge REF_CLK);
        SYS_RST <= 1'h1;
        @(posedge REF_CLK);
        #1;
        chk("reset outputs", 4'h8,
            {REQ_READY, RSP_VALID, DIV_BUSY, USEQ_START});
        @(posedge REF_CLK);
        SYS_RST <= 1'h0;
        run(1'h1, IDU_W32, 64'h0000_0000_0000_0000,
            64'h0000_0000_0000_03e8, 64'h0000_0000_ffff_fff9);
    endtask

    task automatic end_sim();
        if (failures == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // ****************************************
    // clock, sequence and watchdog
    // ****************************************
    initial
    begin
        REF_CLK = 1'h0;
        forever #2.5 REF_CLK = ~REF_CLK;
    end

    // reset, idle outputs, then every scenario
    initial
    begin
        SYS_RST = 1'h1;
        REQ_VALID = 1'h0;
        REQ = '0;
        gdly = 4'h0;
        repeat (20) @(posedge REF_CLK);
        chk("idle outputs", 4'h8,
            {REQ_READY, RSP_VALID, DIV_BUSY, USEQ_START});
        SYS_RST <= 1'h0;
        t_unsigned();
        t_signed();
        t_error();
        t_latency();
        t_reset();
        end_sim();
    end

    // a hung handshake ends the run as a failure
    initial
    begin
        repeat (20000) @(posedge REF_CLK);
        failures++;
        end_sim();
    end
endmodule // integer_divide_unit_test
